// ===== rtl/tss_map.vh
// Register map, field positions, reset values and timing counts of the touch scan control.
// Included by every touch scan design file; holds definitions only.
`ifndef TSS_MAP_VH
`define TSS_MAP_VH

// Register byte addresses.
`define TSS_ADDR_CTRL 8'h00
`define TSS_ADDR_CH0 8'h04
`define TSS_ADDR_CH1 8'h08
`define TSS_ADDR_EN_LO 8'h0C
`define TSS_ADDR_EN_HI 8'h10
`define TSS_ADDR_STAT 8'h14
`define TSS_ADDR_RES 8'h18

// Fields of touch_control_0.
`define TSS_CR_START 0
`define TSS_CR_EXT 1
`define TSS_CR_MODE_LO 2
`define TSS_CR_MODE_HI 3
`define TSS_CR_CLK_LO 4
`define TSS_CR_CLK_HI 5
`define TSS_CR_SYNC 6
`define TSS_CR_HIGH 7
`define TSS_CR_RESET 8'h00

// Measurement modes.
`define TSS_MODE_SINGLE 2'h0
`define TSS_MODE_MULTI 2'h1
`define TSS_MODE_MUTUAL 2'h2

// Operating clock selections.
`define TSS_CLK_DIV1 2'h0
`define TSS_CLK_DIV2 2'h1
`define TSS_CLK_DIV4 2'h2

// Status bits.
`define TSS_ST_BUSY 0
`define TSS_ST_WAIT 1
`define TSS_ST_DONE 2
`define TSS_ST_ERR 3
`define TSS_ST_CUR_LO 8
`define TSS_ST_CUR_HI 13

// Channel codes and sizes.
`define TSS_PINS 36
`define TSS_CH_STOP 6'h3F
`define TSS_CH_LAST 6'h23
`define TSS_CH_RESET 6'h00
`define TSS_EN_RESET 32'h0000_0000
`define TSS_EN_HI_RESET 4'h0

// Measurement window length in operating clock ticks.
`define TSS_WIN_TICKS 16'h0100

`endif

// ===== rtl/tss_clk_div.v
// Operating clock enable for the touch scan control.
// Assumes one free-running peripheral clock; the selection may change at any time.
`timescale 1ns/10ps
`include "tss_map.vh"

module tss_clk_div
(
    // Clock and reset.
    input wire ref_clk,
    input wire rst,
    // Rate selection and tick.
    input wire [1:0] clk_sel,
    output wire op_tick
);
    reg [1:0] cnt_q;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cnt_q <= 2'h0;
        else
            cnt_q <= cnt_q + 2'h1;
    end

    // An undefined selection falls back to the slowest rate.
    assign op_tick = (clk_sel == `TSS_CLK_DIV1) ? 1'b1 :
                     (clk_sel == `TSS_CLK_DIV2) ? (cnt_q[0] == 1'b1) :
                     (cnt_q == 2'h3);
endmodule // tss_clk_div

// ===== rtl/tss_scan_ctrl.v
// Scan control of the capacitive touch sensing unit: registers, trigger, channel walk,
// measurement window with noise prevention, and electrode drive.
// Assumes synchronous inputs on ref_clk and a bus master that never overlaps strobes.
//
// Contract
// - The operating clock is the peripheral clock, or that clock halved or quartered.
// - Up to 36 sense pins 0 to 35 exist, and a reduced variant has a 24-pin subset.
// - Single scan mode measures exactly the one channel named by channel select 0.
// - Multi-scan mode measures every enabled channel in turn by the self method.
// - Mutual full scan measures every enabled channel in turn by the mutual method.
// - A measurement starts on the software start bit or on an event link trigger.
// - Synchronous noise prevention and high-range noise prevention act on every sample.
// - Channel select 0 is a 6-bit binary pin number, 000000 for pin 0 to 100011 for pin 35.
// - Outside single scan mode the all-ones channel code means measurement is stopped.
// - Channel select 1 uses the same 6-bit coding as channel select 0, stop code included.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "tss_map.vh"

module tss_scan_ctrl
#(
    parameter REDUCED = 0
)
(
    // Clock and reset.
    input wire ref_clk,
    input wire rst,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Event link trigger.
    input wire event_trig,
    // Sense electrodes.
    input wire [35:0] sense_pin_in,
    output reg [35:0] sense_pin_out,
    output reg [35:0] sense_pin_oe,
    // Filter capacitor pin.
    output reg filter_cap_pin_en
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ARM = 2'h1;
    localparam ST_MEAS = 2'h2;

    reg [7:0] ctrl_q;
    reg [5:0] ch0_q;
    reg [5:0] ch1_q;
    reg [31:0] en_lo_q;
    reg [3:0] en_hi_q;
    reg [1:0] state_q;
    reg [5:0] cur_q;
    reg [15:0] win_q;
    reg [15:0] acc_q;
    reg [15:0] res_q;
    reg [5:0] res_ch_q;
    reg phase_q;
    reg s0_q;
    reg s1_q;
    reg s2_q;
    reg done_q;
    reg err_q;

    // True where the pin number names an implemented electrode.
    function pin_ok;
        input [5:0] code;
        begin
            if (code > `TSS_CH_LAST)
                pin_ok = 1'b0;
            else if (REDUCED == 0)
                pin_ok = 1'b1;
            else
                pin_ok = (code <= 6'h09) || (code == 6'h0C) || (code == 6'h0D) ||
                         ((code >= 6'h0F) && (code <= 6'h14)) || (code == 6'h16) ||
                         (code == 6'h17) || (code == 6'h1B) || (code == 6'h1E) ||
                         (code == 6'h21) || (code == 6'h23);
        end
    endfunction

    // First enabled channel at or above from; the stop code when none is left.
    function [5:0] next_from;
        input [35:0] en;
        input [6:0] from;
        integer i;
        reg found;
        begin
            next_from = `TSS_CH_STOP;
            found = 1'b0;
            for (i = 0; i < `TSS_PINS; i = i + 1)
            begin
                if (!found && (i >= from) && en[i])
                begin
                    next_from = i[5:0];
                    found = 1'b1;
                end
            end
        end
    endfunction

    wire [35:0] impl_mask;
    genvar g;
    generate
        for (g = 0; g < `TSS_PINS; g = g + 1)
        begin : g_mask
            localparam [31:0] PIN_WIDE = g;
            assign impl_mask[g] = pin_ok(PIN_WIDE[5:0]);
        end
    endgenerate

    wire op_tick;
    tss_clk_div u_div
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_sel(ctrl_q[`TSS_CR_CLK_HI:`TSS_CR_CLK_LO]),
        .op_tick(op_tick)
    );

    wire [1:0] mode = ctrl_q[`TSS_CR_MODE_HI:`TSS_CR_MODE_LO];
    wire single = (mode == `TSS_MODE_SINGLE);
    wire mutual = (mode == `TSS_MODE_MUTUAL);
    wire [35:0] chan_en = {en_hi_q, en_lo_q} & impl_mask;
    wire stop_code = !single && ((ch0_q == `TSS_CH_STOP) || (ch1_q == `TSS_CH_STOP));
    // A start with an unusable code is refused instead of driving a missing pin.
    wire codes_bad = !stop_code && (!pin_ok(ch0_q) || (mutual && !pin_ok(ch1_q)));
    wire [5:0] first_ch = single ? ch0_q : next_from(chan_en, 7'h00);
    wire [5:0] next_ch = single ? `TSS_CH_STOP : next_from(chan_en, {1'b0, cur_q} + 7'h01);

    // Three-sample majority removes short high-range spikes.
    wire maj = (s0_q & s1_q) | (s1_q & s2_q) | (s0_q & s2_q);
    wire sample = ctrl_q[`TSS_CR_HIGH] ? maj : s0_q;
    // Counting only samples that follow the alternating drive cancels noise locked to it.
    wire hit = ctrl_q[`TSS_CR_SYNC] ? (sample == phase_q) : sample;

    wire wr_ctrl = reg_wr && (reg_addr == `TSS_ADDR_CTRL);
    wire wr_stat = reg_wr && (reg_addr == `TSS_ADDR_STAT);
    wire launch = ((state_q == ST_IDLE) && ctrl_q[`TSS_CR_START] && !ctrl_q[`TSS_CR_EXT]) ||
                  ((state_q == ST_ARM) && event_trig);
    wire none_left = (first_ch == `TSS_CH_STOP);
    wire last_tick = (state_q == ST_MEAS) && op_tick && (win_q == 16'h0000);
    wire finish = last_tick && (next_ch == `TSS_CH_STOP);
    wire abort = (state_q != ST_IDLE) && (!ctrl_q[`TSS_CR_START] || stop_code);
    wire refuse = (state_q == ST_IDLE) && ctrl_q[`TSS_CR_START] && (stop_code || codes_bad);

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= `TSS_CR_RESET;
            ch0_q <= `TSS_CH_RESET;
            ch1_q <= `TSS_CH_RESET;
            en_lo_q <= `TSS_EN_RESET;
            en_hi_q <= `TSS_EN_HI_RESET;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= reg_wdata[7:0];
            else if (finish || refuse || (launch && none_left))
                ctrl_q[`TSS_CR_START] <= 1'b0;
            if (reg_wr && (reg_addr == `TSS_ADDR_CH0))
                ch0_q <= reg_wdata[5:0];
            if (reg_wr && (reg_addr == `TSS_ADDR_CH1))
                ch1_q <= reg_wdata[5:0];
            if (reg_wr && (reg_addr == `TSS_ADDR_EN_LO))
                en_lo_q <= reg_wdata;
            if (reg_wr && (reg_addr == `TSS_ADDR_EN_HI))
                en_hi_q <= reg_wdata[3:0];
            // Hardware set wins over a write-one clear in the same cycle.
            if (finish || (launch && none_left))
                done_q <= 1'b1;
            else if (wr_stat && reg_wdata[`TSS_ST_DONE])
                done_q <= 1'b0;
            if (refuse && codes_bad)
                err_q <= 1'b1;
            else if (wr_stat && reg_wdata[`TSS_ST_ERR])
                err_q <= 1'b0;
        end
    end

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            cur_q <= `TSS_CH_RESET;
            win_q <= 16'h0000;
            acc_q <= 16'h0000;
            res_q <= 16'h0000;
            res_ch_q <= `TSS_CH_RESET;
            phase_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (refuse)
                        state_q <= ST_IDLE;
                    else if (ctrl_q[`TSS_CR_START] && ctrl_q[`TSS_CR_EXT])
                        state_q <= ST_ARM;
                    else if (launch && !none_left)
                    begin
                        state_q <= ST_MEAS;
                        cur_q <= first_ch;
                        win_q <= `TSS_WIN_TICKS - 16'h0001;
                        acc_q <= 16'h0000;
                        phase_q <= 1'b0;
                    end
                end
                ST_ARM:
                begin
                    if (abort || (launch && none_left))
                        state_q <= ST_IDLE;
                    else if (launch)
                    begin
                        state_q <= ST_MEAS;
                        cur_q <= first_ch;
                        win_q <= `TSS_WIN_TICKS - 16'h0001;
                        acc_q <= 16'h0000;
                        phase_q <= 1'b0;
                    end
                end
                ST_MEAS:
                begin
                    if (abort)
                        state_q <= ST_IDLE;
                    else if (op_tick)
                    begin
                        phase_q <= ~phase_q;
                        if (win_q == 16'h0000)
                        begin
                            res_q <= acc_q + {15'h0000, hit};
                            res_ch_q <= cur_q;
                            acc_q <= 16'h0000;
                            win_q <= `TSS_WIN_TICKS - 16'h0001;
                            phase_q <= 1'b0;
                            if (next_ch == `TSS_CH_STOP)
                                state_q <= ST_IDLE;
                            else
                                cur_q <= next_ch;
                        end
                        else
                        begin
                            win_q <= win_q - 16'h0001;
                            acc_q <= acc_q + {15'h0000, hit};
                        end
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Sample pipeline of the channel under measurement.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s0_q <= 1'b0;
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            filter_cap_pin_en <= 1'b0;
        end
        else
        begin
            if (op_tick)
            begin
                s0_q <= sense_pin_in[cur_q];
                s1_q <= s0_q;
                s2_q <= s1_q;
            end
            filter_cap_pin_en <= (state_q == ST_MEAS);
        end
    end

    // Self methods drive the measured pin; the mutual method drives channel select 1 as
    // transmitter and leaves the measured receiver pin undriven.
    wire [35:0] oe_d;
    wire [35:0] out_d;
    generate
        for (g = 0; g < `TSS_PINS; g = g + 1)
        begin : g_pin
            localparam [31:0] PIN_WIDE = g;
            wire drv = (state_q == ST_MEAS) &&
                       (mutual ? (ch1_q == PIN_WIDE[5:0]) : (cur_q == PIN_WIDE[5:0]));
            assign oe_d[g] = drv;
            assign out_d[g] = drv && (phase_q || (!mutual && !ctrl_q[`TSS_CR_SYNC]));
        end
    endgenerate

    // One process owns both electrode vectors so every bit has a single driver.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sense_pin_oe <= 36'h0_0000_0000;
            sense_pin_out <= 36'h0_0000_0000;
        end
        else
        begin
            sense_pin_oe <= oe_d;
            sense_pin_out <= out_d;
        end
    end

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `TSS_ADDR_CTRL: reg_rdata <= {24'h00_0000, ctrl_q};
                `TSS_ADDR_CH0: reg_rdata <= {26'h000_0000, ch0_q};
                `TSS_ADDR_CH1: reg_rdata <= {26'h000_0000, ch1_q};
                `TSS_ADDR_EN_LO: reg_rdata <= en_lo_q;
                `TSS_ADDR_EN_HI: reg_rdata <= {28'h000_0000, en_hi_q};
                `TSS_ADDR_STAT: reg_rdata <= {18'h0_0000, cur_q, 4'h0, err_q, done_q,
                                              (state_q == ST_ARM), (state_q == ST_MEAS)};
                `TSS_ADDR_RES: reg_rdata <= {10'h000, res_ch_q, res_q};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end
endmodule // tss_scan_ctrl

// ===== tb/tss_scan_chk.sv
// Port checker of the touch scan control.
// Sees only the ports of tss_scan_ctrl; attached by the bind below.
`timescale 1ns/10ps
`include "tss_map.vh"

module tss_scan_chk
#(
    parameter REDUCED = 0
)
(
    // Clock and reset.
    input wire ref_clk,
    input wire rst,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // Trigger and electrodes.
    input wire event_trig,
    input wire [35:0] sense_pin_in,
    input wire [35:0] sense_pin_out,
    input wire [35:0] sense_pin_oe,
    input wire filter_cap_pin_en
);
    localparam [35:0] PIN_MASK = REDUCED ? 36'hA_48DF_B3FF : 36'hF_FFFF_FFFF;
    reg [5:0] ch0_q;
    reg [5:0] ch1_q;
    reg [9:0] run_q;
    reg stop_q;
    wire ctl_wr = reg_wr && reg_addr == `TSS_ADDR_CTRL && reg_wdata[0] && !filter_cap_pin_en;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ch0_q <= 6'h00;
            ch1_q <= 6'h00;
            run_q <= 10'h000;
            stop_q <= 1'b0;
        end
        else
        begin
            // A control or channel write during a run may legally cut the window short.
            if (!filter_cap_pin_en)
                stop_q <= 1'b0;
            else if (reg_wr && (reg_addr == `TSS_ADDR_CTRL || reg_addr == `TSS_ADDR_CH0 ||
                     reg_addr == `TSS_ADDR_CH1))
                stop_q <= 1'b1;
            if (reg_wr && reg_addr == `TSS_ADDR_CH0)
                ch0_q <= reg_wdata[5:0];
            if (reg_wr && reg_addr == `TSS_ADDR_CH1)
                ch1_q <= reg_wdata[5:0];
            if (!filter_cap_pin_en)
                run_q <= 10'h000;
            else if (run_q != 10'h3FF)
                run_q <= run_q + 10'h001;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_sw_start;
        ctl_wr && !reg_wdata[1] && reg_wdata[3:2] == `TSS_MODE_SINGLE && PIN_MASK[ch0_q];
    endsequence
    sequence s_ext_start;
        ctl_wr && reg_wdata[1] && !event_trig ##1 (!event_trig)[*3];
    endsequence

    AST_ONE_PIN: assert property ($countones(sense_pin_oe) <= 1)
        else $error("more than one electrode driven");
    AST_PIN_SET: assert property ((sense_pin_oe & ~PIN_MASK) == 36'h0_0000_0000)
        else $error("absent electrode driven");
    AST_DRIVE_CAP: assert property (|sense_pin_oe |-> filter_cap_pin_en)
        else $error("electrode driven outside a measurement");
    AST_SW_LAUNCH: assert property (s_sw_start |-> ##[1:5] filter_cap_pin_en)
        else $error("software start did not launch");
    AST_EXT_HOLD: assert property (s_ext_start |-> !filter_cap_pin_en)
        else $error("launch without event trigger");
    AST_STOP_CODE: assert property (ctl_wr && reg_wdata[3:2] != `TSS_MODE_SINGLE
        && (ch0_q == `TSS_CH_STOP || ch1_q == `TSS_CH_STOP) |=> (!filter_cap_pin_en)[*6])
        else $error("stop code did not hold measurement off");
    AST_WINDOW_LEN: assert property ($fell(filter_cap_pin_en) && !stop_q |-> run_q >= 10'h0FF)
        else $error("measurement window too short");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read answer cycle");
    AST_OUT_OE: assert property ((sense_pin_out & ~sense_pin_oe) == 36'h0_0000_0000)
        else $error("electrode level shown on a released pin");
endmodule // tss_scan_chk

bind tss_scan_ctrl tss_scan_chk #(.REDUCED(REDUCED)) u_chk (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .event_trig(event_trig), .sense_pin_in(sense_pin_in),
    .sense_pin_out(sense_pin_out), .sense_pin_oe(sense_pin_oe),
    .filter_cap_pin_en(filter_cap_pin_en));

// ===== tb/tss_electrodes.sv
// Electrode model: a driven pin charges and echoes its drive one cycle later.
// A floating pin toggles every cycle so no stale level can look like a hit.
`timescale 1ns/10ps

module tss_electrodes
(
    // Clock.
    input wire ref_clk,
    // Electrode side.
    input wire [35:0] sense_pin_out,
    input wire [35:0] sense_pin_oe,
    output reg [35:0] sense_pin_in
);
    reg [35:0] float_q;
    initial float_q = 36'h5_5555_5555;
    initial sense_pin_in = 36'h0_0000_0000;
    always @(posedge ref_clk)
    begin
        float_q <= ~float_q;
        sense_pin_in <= (sense_pin_oe & sense_pin_out) | (~sense_pin_oe & float_q);
    end
endmodule // tss_electrodes

// ===== tb/test_touch_sense_scan_control.sv
// Self-checking bench of the touch scan control with the electrode model.
// Assumes tss_map.vh on the include path; reads are checked against queued notes.
`timescale 1ns/10ps
`include "tss_map.vh"

module test_touch_sense_scan_control;
    reg ref_clk, rst, reg_wr, reg_rd, event_trig, rd_d;
    reg [7:0] reg_addr;
    reg [31:0] reg_wdata, last_rd;
    wire [31:0] reg_rdata;
    wire [35:0] pin_in, pin_out, pin_oe;
    wire cap_en;
    integer seed, miscompares, total_checks, md, ck, ch, n, a;
    time t0;
    reg [63:0] note_q[$];

    tss_scan_ctrl uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .event_trig(event_trig), .sense_pin_in(pin_in), .sense_pin_out(pin_out),
        .sense_pin_oe(pin_oe), .filter_cap_pin_en(cap_en));
    tss_electrodes u_elec (.ref_clk(ref_clk), .sense_pin_out(pin_out),
        .sense_pin_oe(pin_oe), .sense_pin_in(pin_in));

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task print_verdict;
    begin
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask

    task cmp_reg(input [31:0] got, input [31:0] exp, input [31:0] mask);
    begin
        total_checks = total_checks + 1;
        if ((got & mask) !== (exp & mask))
        begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
        end
    end
    endtask

    task cmp_cnt(input integer got, input integer lo, input integer hi);
    begin
        total_checks = total_checks + 1;
        if (got < lo || got > hi)
        begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: scan took %0d cycles", $time, got);
        end
    end
    endtask

    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    end
    endtask

    // A zero mask only collects the data, for polling.
    task rd(input [7:0] a, input [31:0] e, input [31:0] m);
    begin
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        note_q.push_back({e, m});
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    end
    endtask

    always @(posedge ref_clk)
    begin
        if (rd_d && note_q.size() > 0)
        begin
            last_rd = reg_rdata;
            if (note_q[0][31:0] !== 32'h0000_0000)
                cmp_reg(reg_rdata, note_q[0][63:32], note_q[0][31:0]);
            note_q.pop_front();
        end
        rd_d <= reg_rd;
    end

    task wait_done;
    begin
        n = 0;
        last_rd = 32'h0000_0000;
        while (last_rd[`TSS_ST_DONE] !== 1'b1 && n < 3000)
        begin
            rd(`TSS_ADDR_STAT, 32'h0000_0000, 32'h0000_0000);
            @(posedge ref_clk);
            #1;
            n = n + 1;
        end
        if (n >= 3000)
        begin
            miscompares = miscompares + 1;
            print_verdict;
        end
    end
    endtask

    initial
    begin
        seed = 7;
        miscompares = 0;
        total_checks = 0;
        rd_d = 1'b0;
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        event_trig = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        // Every register, and one unmapped place, reads zero after reset.
        for (a = 0; a < 32; a = a + 4)
            rd(a, 32'h0000_0000, 32'hFFFF_FFFF);
        wr(`TSS_ADDR_CH0, 32'h0000_0023);
        rd(`TSS_ADDR_CH0, 32'h0000_0023, 32'h0000_003F);
        wr(`TSS_ADDR_CH1, 32'h0000_003F);
        rd(`TSS_ADDR_CH1, 32'h0000_003F, 32'h0000_003F);
        wr(`TSS_ADDR_EN_LO, 32'h0000_0001);
        wr(`TSS_ADDR_EN_HI, 32'h0000_0008);
        for (ck = 0; ck < 3; ck = ck + 1)
            for (md = 0; md < 3; md = md + 1)
            begin
                ch = $unsigned($random(seed)) % 36;
                wr(`TSS_ADDR_CH0, ch);
                wr(`TSS_ADDR_CH1, 32'h0000_0001);
                t0 = $time;
                wr(`TSS_ADDR_CTRL, {24'h00_0000, 2'b11, ck[1:0], md[1:0], 2'b01});
                wait_done;
                n = (md == 0) ? (256 << ck) : (512 << ck);
                cmp_cnt(($time - t0) / 25, n, n + 16);
                rd(`TSS_ADDR_STAT, 32'h0000_0004, 32'h0000_000F);
                rd(`TSS_ADDR_CTRL, 32'h0000_0000, 32'h0000_0001);
                rd(`TSS_ADDR_RES, ((md == 0) ? ch : 35) << 16, 32'h003F_0000);
                wr(`TSS_ADDR_STAT, 32'h0000_0004);
            end
        wr(`TSS_ADDR_CH0, 32'h0000_0007);
        wr(`TSS_ADDR_CTRL, 32'h0000_0003);
        repeat (4) @(posedge ref_clk);
        rd(`TSS_ADDR_STAT, 32'h0000_0002, 32'h0000_0006);
        event_trig <= 1'b1;
        @(posedge ref_clk);
        event_trig <= 1'b0;
        wait_done;
        rd(`TSS_ADDR_RES, 32'h0007_0000, 32'h003F_0000);
        wr(`TSS_ADDR_STAT, 32'h0000_0004);
        // Rewriting a channel select to the stop code ends a running scan early.
        wr(`TSS_ADDR_CTRL, 32'h0000_0005);
        repeat (20) @(posedge ref_clk);
        rd(`TSS_ADDR_STAT, 32'h0000_0001, 32'h0000_0001);
        wr(`TSS_ADDR_CH0, 32'h0000_003F);
        rd(`TSS_ADDR_STAT, 32'h0000_0000, 32'h0000_000D);
        wr(`TSS_ADDR_CH0, 32'h0000_003F);
        wr(`TSS_ADDR_CTRL, 32'h0000_0005);
        rd(`TSS_ADDR_CTRL, 32'h0000_0000, 32'h0000_0001);
        rd(`TSS_ADDR_STAT, 32'h0000_0000, 32'h0000_000D);
        wr(`TSS_ADDR_CH0, 32'h0000_0000);
        wr(`TSS_ADDR_CH1, 32'h0000_003F);
        wr(`TSS_ADDR_CTRL, 32'h0000_0009);
        rd(`TSS_ADDR_CTRL, 32'h0000_0000, 32'h0000_0001);
        rd(`TSS_ADDR_STAT, 32'h0000_0000, 32'h0000_000D);
        wr(`TSS_ADDR_CH0, 32'h0000_0024);
        wr(`TSS_ADDR_CTRL, 32'h0000_0001);
        rd(`TSS_ADDR_STAT, 32'h0000_0008, 32'h0000_000D);
        repeat (4) @(posedge ref_clk);
        print_verdict;
    end
endmodule // test_touch_sense_scan_control
